// >>> verilog/pmec_map.svh
// Offsets, field positions, reset values and codes of the power-mode entry control
`ifndef PMEC_MAP_SVH
`define PMEC_MAP_SVH
`define PMEC_ADDR_PCTRL 8'h87
`define PMEC_ADDR_SLEEP 8'hbe
`define PMEC_BIT_ENTRY 0
`define PMEC_BIT_CPUSTOP 1
`define PMEC_BIT_USB_EN 7
`define PMEC_BIT_XTAL_RDY 6
`define PMEC_BIT_FRC_RDY 5
`define PMEC_RST_MSB 4
`define PMEC_RST_LSB 3
`define PMEC_MODE_MSB 1
`define PMEC_MODE_LSB 0
`define PMEC_PCTRL_RESET 8'h00
`define PMEC_MODE_RESET 2'h0
`define PMEC_CAUSE_POR 2'h0
`define PMEC_CAUSE_EXT 2'h1
`define PMEC_CAUSE_WDT 2'h2
`endif

// >>> verilog/pmec_pkg.sv
// Types shared by the power-mode entry control
`default_nettype none
package pmec_pkg;
    typedef enum logic [1:0] {
        PMEC_HALT = 2'b00,
        PMEC_LIGHT = 2'b01,
        PMEC_TIMER = 2'b10,
        PMEC_DEEP = 2'b11
    } pmec_level_t;
    typedef enum logic [2:0] {
        PMEC_ACTIVE = 3'b000,
        PMEC_IN_HALT = 3'b001,
        PMEC_IN_LIGHT = 3'b010,
        PMEC_IN_TIMER = 3'b011,
        PMEC_IN_DEEP = 3'b100
    } pmec_state_t;
    // Register access strobe bundle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmec_acc_t;
    // Wake sources
    typedef struct packed {
        logic any_irq;
        logic pin_irq;
        logic timer_irq;
    } pmec_wake_t;
endpackage
`default_nettype wire

// >>> verilog/pmec_cause.sv
// Last-reset cause capture
`timescale 1ns/100ps
`default_nettype none
`include "pmec_map.svh"
module pmec_cause (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic por_flag,
    input wire logic ext_flag,
    input wire logic wdt_flag,
    output logic [1:0] cause
);
    logic [1:0] cause_r, cause_nxt;
    logic armed_r, armed_nxt;

    // Cause is sampled at the first clock after release, never under reset
    always_comb begin
        cause_nxt = cause_r;
        armed_nxt = 1'b0;
        if (armed_r) begin
            if (wdt_flag)
                cause_nxt = `PMEC_CAUSE_WDT;
            else if (ext_flag)
                cause_nxt = `PMEC_CAUSE_EXT;
            else if (por_flag)
                cause_nxt = `PMEC_CAUSE_POR;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cause_r <= `PMEC_CAUSE_POR;
            armed_r <= 1'b1;
        end else begin
            cause_r <= cause_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign cause = cause_r;
endmodule
`default_nettype wire

// >>> verilog/pmec_top.sv
// Power-mode entry control: mode field, entry strobe, sleep status register
`timescale 1ns/100ps
`default_nettype none
`include "pmec_map.svh"
module pmec_top (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire pmec_pkg::pmec_acc_t acc,
    output logic [7:0] rdata,
    input wire pmec_pkg::pmec_wake_t wake,
    input wire logic crystal_ready_flag,
    input wire logic fast_rc_ready_flag,
    input wire logic por_flag,
    input wire logic ext_flag,
    input wire logic wdt_flag,
    output logic cpu_clk_gate,
    output logic cpu_stop,
    output logic osc_off,
    output logic core_power_off,
    output logic usb_enable,
    output logic usb_reset,
    output logic [2:0] power_state
);
    // ********************************
    // Storage
    // ********************************
    pmec_pkg::pmec_state_t state_r, state_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [5:0] spare_r, spare_nxt;
    logic stop_r, stop_nxt;
    logic usb_r, usb_nxt;
    logic usb_rst_r, usb_rst_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [1:0] cause;
    logic wr_pctrl, wr_sleep, wake_now;

    assign wr_pctrl = acc.wr && (acc.addr == `PMEC_ADDR_PCTRL);
    assign wr_sleep = acc.wr && (acc.addr == `PMEC_ADDR_SLEEP);

    pmec_cause u_cause (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .por_flag(por_flag),
        .ext_flag(ext_flag),
        .wdt_flag(wdt_flag),
        .cause(cause)
    );

    // Wake test per state; deepest sleep ignores the sleep timer
    always_comb begin
        case (state_r)
            pmec_pkg::PMEC_ACTIVE: wake_now = 1'b0;
            pmec_pkg::PMEC_IN_HALT: wake_now = wake.any_irq | wake.pin_irq | wake.timer_irq;
            pmec_pkg::PMEC_IN_LIGHT: wake_now = wake.pin_irq | wake.timer_irq | wake.any_irq;
            pmec_pkg::PMEC_IN_TIMER: wake_now = wake.pin_irq | wake.timer_irq | wake.any_irq;
            pmec_pkg::PMEC_IN_DEEP: wake_now = wake.pin_irq | wake.any_irq;
            default: wake_now = 1'b1;
        endcase
    end

    // ********************************
    // Mode state machine and registers
    // ********************************
    // Writes while asleep are taken, so ports of a halted core cannot hang
    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        spare_nxt = spare_r;
        stop_nxt = stop_r;
        usb_nxt = usb_r;
        usb_rst_nxt = 1'b0;
        if (wr_sleep) begin
            mode_nxt = acc.wdata[`PMEC_MODE_MSB:`PMEC_MODE_LSB];
            usb_nxt = acc.wdata[`PMEC_BIT_USB_EN];
            usb_rst_nxt = ~acc.wdata[`PMEC_BIT_USB_EN];
        end
        if (wr_pctrl) begin
            spare_nxt = acc.wdata[7:2];
            stop_nxt = acc.wdata[`PMEC_BIT_CPUSTOP];
        end
        case (state_r)
            pmec_pkg::PMEC_ACTIVE: begin
                // entry strobe starts the selected level
                if (wr_pctrl && acc.wdata[`PMEC_BIT_ENTRY]) begin
                    case (mode_r)
                        pmec_pkg::PMEC_HALT: state_nxt = pmec_pkg::PMEC_IN_HALT;
                        pmec_pkg::PMEC_LIGHT: state_nxt = pmec_pkg::PMEC_IN_LIGHT;
                        pmec_pkg::PMEC_TIMER: state_nxt = pmec_pkg::PMEC_IN_TIMER;
                        default: state_nxt = pmec_pkg::PMEC_IN_DEEP;
                    endcase
                    mode_nxt = `PMEC_MODE_RESET;
                end
            end
            pmec_pkg::PMEC_IN_HALT, pmec_pkg::PMEC_IN_LIGHT: begin
                if (wake_now) begin
                    state_nxt = pmec_pkg::PMEC_ACTIVE;
                    mode_nxt = `PMEC_MODE_RESET;
                end
            end
            pmec_pkg::PMEC_IN_TIMER, pmec_pkg::PMEC_IN_DEEP: begin
                // wake clears mode; USB off after deep levels
                if (wake_now) begin
                    state_nxt = pmec_pkg::PMEC_ACTIVE;
                    mode_nxt = `PMEC_MODE_RESET;
                    usb_nxt = 1'b0;
                end
            end
            default: state_nxt = pmec_pkg::PMEC_ACTIVE;
        endcase
    end

    // mode cleared on sleep entry and on wake; usb cleared on timer/deep wake, usb reset pulses one cycle; other storage holds
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= pmec_pkg::PMEC_ACTIVE;
            mode_r <= `PMEC_MODE_RESET;
            spare_r <= 6'h00;
            stop_r <= 1'b0;
            usb_r <= 1'b0;
            usb_rst_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            spare_r <= spare_nxt;
            stop_r <= stop_nxt;
            usb_r <= usb_nxt;
            usb_rst_r <= usb_rst_nxt;
        end
    end

    // ********************************
    // Read path
    // ********************************
    // Registered read data, valid the cycle after rd; entry bit reads zero
    always_comb begin
        rdata_nxt = rdata_r;
        if (acc.rd) begin
            if (acc.addr == `PMEC_ADDR_PCTRL)
                rdata_nxt = {spare_r, stop_r, 1'b0};
            else if (acc.addr == `PMEC_ADDR_SLEEP)
                rdata_nxt = {usb_r, crystal_ready_flag, fast_rc_ready_flag, cause, 1'b0, mode_r};
            else
                rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            rdata_r <= 8'h00;
        else
            rdata_r <= rdata_nxt;
    end

    // Outputs; halt gates only the core clock, peripherals keep running
    // clock gate in every sleep state
    assign cpu_clk_gate = (state_r != pmec_pkg::PMEC_ACTIVE);
    assign cpu_stop = stop_r;
    assign osc_off = (state_r != pmec_pkg::PMEC_ACTIVE) && (state_r != pmec_pkg::PMEC_IN_HALT);
    assign core_power_off = (state_r == pmec_pkg::PMEC_IN_TIMER)
        || (state_r == pmec_pkg::PMEC_IN_DEEP);
    assign usb_enable = usb_r;
    assign usb_reset = usb_rst_r;
    assign power_state = state_r;
    assign rdata = rdata_r;

    // ********************************
    // Checks
    // ********************************
    // mode zero after entry
    mode_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_r == pmec_pkg::PMEC_ACTIVE && wr_pctrl && acc.wdata[0] && !wr_sleep)
        |=> (mode_r == 2'h0 && state_r != pmec_pkg::PMEC_ACTIVE))
        else $error("mode not cleared on entry");
    irq_wake_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_r != pmec_pkg::PMEC_ACTIVE && wake.any_irq) |=> state_r == pmec_pkg::PMEC_ACTIVE)
        else $error("interrupt did not wake");
    usb_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_r == pmec_pkg::PMEC_IN_DEEP && wake_now) |=> !usb_r)
        else $error("usb still enabled after deep sleep");
    strobe_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (acc.rd && acc.addr == `PMEC_ADDR_PCTRL) |=> !rdata_r[0])
        else $error("entry bit read as one");
    usb_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wr_sleep && !acc.wdata[`PMEC_BIT_USB_EN]) |=> (usb_reset && !usb_enable))
        else $error("usb reset pulse missing");
    // sleep timer cannot wake deepest sleep
    deep_timer_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state_r == pmec_pkg::PMEC_IN_DEEP && !wake.any_irq && !wake.pin_irq)
        |=> state_r == pmec_pkg::PMEC_IN_DEEP)
        else $error("deepest sleep left without a wake source");
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking bench for the power-mode entry control
`timescale 1ns/100ps
`default_nettype none
`include "pmec_map.svh"
module tb;
    logic clk_sys;
    logic resetn;
    pmec_pkg::pmec_acc_t acc;
    pmec_pkg::pmec_wake_t wake;
    logic [7:0] rdata;
    logic crystal_ready_flag, fast_rc_ready_flag, por_flag, ext_flag, wdt_flag;
    logic cpu_clk_gate, cpu_stop, osc_off, core_power_off, usb_enable, usb_reset;
    logic [2:0] power_state;
    int err_count = 0;
    int checks_done = 0;

    pmec_top pmec_top_i (.clk_sys(clk_sys), .resetn(resetn), .acc(acc), .rdata(rdata),
        .wake(wake), .crystal_ready_flag(crystal_ready_flag),
        .fast_rc_ready_flag(fast_rc_ready_flag), .por_flag(por_flag), .ext_flag(ext_flag),
        .wdt_flag(wdt_flag), .cpu_clk_gate(cpu_clk_gate), .cpu_stop(cpu_stop),
        .osc_off(osc_off), .core_power_off(core_power_off), .usb_enable(usb_enable),
        .usb_reset(usb_reset), .power_state(power_state));

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Strobe is held for exactly one sampling edge, then dropped
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) acc <= {1'b1, 1'b0, a, d};
        @(posedge clk_sys) acc <= '0;
    endtask

    // Data is registered at the sampling edge, so one more edge before looking
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) acc <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys) acc <= '0;
        @(posedge clk_sys) #1 d = rdata;
    endtask

    task automatic pulse(input logic [2:0] w);
        @(posedge clk_sys) wake <= w;
        @(posedge clk_sys) wake <= '0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // Cause flags stay up across the first edge after release
    task automatic do_reset(input logic p, input logic e, input logic w);
        resetn <= 1'b0;
        por_flag <= p;
        ext_flag <= e;
        wdt_flag <= w;
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        por_flag <= 1'b0;
        ext_flag <= 1'b0;
        wdt_flag <= 1'b0;
    endtask

    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #(50 * 5000);
        err_count++;
        conclude();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        logic [7:0] v;
        logic [1:0] md;
        acc = '0;
        wake = '0;
        {crystal_ready_flag, fast_rc_ready_flag} = 2'h0;
        do_reset(1'b1, 1'b0, 1'b0);
        rd(`PMEC_ADDR_PCTRL, v); check(v, 8'h00);
        rd(`PMEC_ADDR_SLEEP, v); check(v, 8'h00);
        rd(8'h55, v); check(v, 8'h00);
        wr(8'h33, 8'hff);
        // Storage bits hold, entry strobe reads zero even while written idle
        wr(`PMEC_ADDR_PCTRL, 8'hfc);
        rd(`PMEC_ADDR_PCTRL, v); check(v, 8'hfc);
        check({7'h00, cpu_stop}, 8'h00);
        crystal_ready_flag <= 1'b1;
        rd(`PMEC_ADDR_SLEEP, v); check(v, 8'h40);
        crystal_ready_flag <= 1'b0;
        fast_rc_ready_flag <= 1'b1;
        rd(`PMEC_ADDR_SLEEP, v); check(v, 8'h20);
        wr(`PMEC_ADDR_SLEEP, 8'h80);
        #1 check({7'h00, usb_enable}, 8'h01);
        @(posedge clk_sys) acc <= {1'b1, 1'b0, `PMEC_ADDR_SLEEP, 8'h00};
        @(posedge clk_sys) acc <= '0;
        #1 check({6'h00, usb_enable, usb_reset}, 8'h01);
        // crystal stable before any deeper level
        crystal_ready_flag <= 1'b1;
        // Every level: enter, look at the outputs, wake, look again
        for (int m = 0; m < 4; m++) begin
            md = m[1:0];
            // wake lines idle while each level is set
            wr(`PMEC_ADDR_SLEEP, {6'h20, md});
            // entry strobe follows the mode write after one idle edge
            wr(`PMEC_ADDR_PCTRL, 8'hfd);
            repeat (2) @(posedge clk_sys);
            #1 check({5'h00, power_state}, 8'(m + 1));
            check({5'h00, cpu_clk_gate, osc_off, core_power_off},
                {5'h00, 1'b1, md != 2'h0, md[1]});
            rd(`PMEC_ADDR_SLEEP, v); check(v & 8'h03, 8'h00);
            if (m == 3) begin
                pulse(3'b001);
                check({5'h00, power_state}, 8'h04);
            end
            pulse(m == 0 ? 3'b100 : (m == 2 ? 3'b001 : 3'b010));
            check({5'h00, power_state}, 8'h00);
            check({7'h00, usb_enable}, {7'h00, ~md[1]});
            // PCTRL storage bits read back unchanged after each wake
            rd(`PMEC_ADDR_PCTRL, v); check(v, 8'hfc);
        end
        // A second entry strobe, sent during the sleep, is refused
        wr(`PMEC_ADDR_SLEEP, 8'h01);
        wr(`PMEC_ADDR_PCTRL, 8'h01);
        wr(`PMEC_ADDR_PCTRL, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 check({5'h00, power_state}, 8'h02);
        pulse(3'b010);
        // Reset cause codes
        do_reset(1'b0, 1'b1, 1'b0);
        rd(`PMEC_ADDR_SLEEP, v); check(v & 8'h18, 8'h08);
        do_reset(1'b0, 1'b1, 1'b1);
        rd(`PMEC_ADDR_SLEEP, v); check(v & 8'h18, 8'h10);
        do_reset(1'b1, 1'b0, 1'b0);
        rd(`PMEC_ADDR_SLEEP, v); check(v & 8'h18, 8'h00);
        conclude();
    end
endmodule
`default_nettype wire
